// file: logic/msna_pkg.sv
// shared constants for the microsequencer next-address block
`default_nettype none

package msna_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int ADDR_W      = 12;
    localparam int OPCODE_W    = 4;
    localparam int STACK_DEPTH = 8;

    ////////////////////////////////////////////////////////////////////////////
    // instruction codes handled by this block
    localparam logic [OPCODE_W-1:0] PUSH_LOAD_OP             = 4'h4;
    localparam logic [OPCODE_W-1:0] REPEAT_FROM_PIPELINE_OP  = 4'h9;
    localparam logic [OPCODE_W-1:0] COND_RETURN_OP           = 4'hA;
    localparam logic [OPCODE_W-1:0] COND_JUMP_POP_OP         = 4'hB;
    localparam logic [OPCODE_W-1:0] LOAD_COUNTER_CONTINUE_OP = 4'hC;
    localparam logic [OPCODE_W-1:0] END_OF_LOOP_OP           = 4'hD;
    localparam logic [OPCODE_W-1:0] CONTINUE_OP              = 4'hE;
    localparam logic [OPCODE_W-1:0] THREE_WAY_BRANCH_OP      = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset and the unit address step
    localparam logic [ADDR_W-1:0] ADDR_RESET    = 12'h000;
    localparam logic [ADDR_W-1:0] PC_RESET      = 12'h001;
    localparam logic [ADDR_W-1:0] COUNTER_RESET = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_ONE      = 12'h001;

    ////////////////////////////////////////////////////////////////////////////
    // address source, stack action and counter action
    typedef enum logic [1:0] {
        SRC_PC,
        SRC_DATA,
        SRC_STACK
    } msna_src_t;

    typedef enum logic [1:0] {
        STK_HOLD,
        STK_PUSH,
        STK_POP
    } msna_stk_t;

    typedef enum logic [1:0] {
        CNT_HOLD,
        CNT_LOAD,
        CNT_DEC
    } msna_cnt_t;

endpackage

`default_nettype wire

// file: logic/msna_next_address.sv
// next-address selection, stack and loop counter of the microsequencer
`default_nettype none

// Notes on behaviour
// - repeat: counter nonzero takes data, else counter
// - repeat never touches stack or pointer
// - cond return: pass pops stack top, fail counter
// - jump-pop: pass takes data and pops
// - jump-pop fail: counter address, stack untouched
// - load counter from data, continue sequentially
// - end-of-loop fail: stack top, no pop
// - end-of-loop pass: continue sequentially and pop
// - pointer always marks one past the top entry still on the stack
// - continue: microprogram counter as next address
// - three-way pass: counter address, pop, any count
// - three-way fail nonzero: stack top, decrement
// - three-way fail zero: pop, take data
// - enable high forces a passed test
// - fail only when enable low, condition high
module msna_next_address
    import msna_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W,
    parameter int DEPTH      = STACK_DEPTH
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic [OPCODE_W-1:0]   opcode,
    input  wire logic [ADDR_WIDTH-1:0] dataIn,
    input  wire logic                  cond_test_enable_n,
    input  wire logic                  cond_input_n,
    output var  logic [ADDR_WIDTH-1:0] nextAddr,
    output var  logic [ADDR_WIDTH-1:0] counterValue,
    output var  logic                  counterZero,
    output var  logic [$clog2(DEPTH+1)-1:0] stackLevel,
    output var  logic                  stackFull_n,
    output var  logic                  pipelineEnable_n
);

    localparam int PTR_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_EMPTY = '0;
    localparam logic [PTR_W-1:0] PTR_FULL  = PTR_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_ONE   = PTR_W'(1);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [ADDR_WIDTH-1:0]            yAddr;
        logic [ADDR_WIDTH-1:0]            pc;
        logic [ADDR_WIDTH-1:0]            counter;
        logic                             zero;
        logic [PTR_W-1:0]                 level;
        logic                             full_n;
        logic                             plEn_n;
        logic [DEPTH-1:0][ADDR_WIDTH-1:0] stack;
    } msna_state_t;

    msna_state_t state_q;
    msna_state_t state_d;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic testPassed(input logic enable_n, input logic cond_n);
        // enable high forces the pass; only an enabled high condition fails
        testPassed = enable_n || !cond_n;
    endfunction

    function automatic logic [ADDR_WIDTH-1:0] stackTop(
        input logic [DEPTH-1:0][ADDR_WIDTH-1:0] stk,
        input logic [PTR_W-1:0]                 lvl
    );
        logic [PTR_W-1:0] idx;
        idx = (lvl == PTR_EMPTY) ? PTR_EMPTY : lvl - PTR_ONE;
        // pointer marks one past the top entry still on the stack
        stackTop = stk[idx];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // decode

    logic                  pass;
    logic                  cntZero;
    logic [ADDR_WIDTH-1:0] topWord;
    msna_src_t             src;
    msna_stk_t             stk;
    msna_cnt_t             cnt;

    always_comb begin
        pass    = testPassed(cond_test_enable_n, cond_input_n);
        cntZero = state_q.counter == '0;
        topWord = stackTop(state_q.stack, state_q.level);
        src     = SRC_PC;
        stk     = STK_HOLD;
        cnt     = CNT_HOLD;
        unique case (opcode)
            PUSH_LOAD_OP: begin
                // needed so loops can seed the stack; load only on pass
                stk = STK_PUSH;
                cnt = pass ? CNT_LOAD : CNT_HOLD;
            end
            REPEAT_FROM_PIPELINE_OP: begin
                // stack left alone on either branch
                src = cntZero ? SRC_PC : SRC_DATA;
                cnt = cntZero ? CNT_HOLD : CNT_DEC;
            end
            COND_RETURN_OP: begin
                src = pass ? SRC_STACK : SRC_PC;
                stk = pass ? STK_POP : STK_HOLD;
            end
            COND_JUMP_POP_OP: begin
                src = pass ? SRC_DATA : SRC_PC;
                stk = pass ? STK_POP : STK_HOLD;
            end
            LOAD_COUNTER_CONTINUE_OP: begin
                src = SRC_PC;
                cnt = CNT_LOAD;
            end
            END_OF_LOOP_OP: begin
                src = pass ? SRC_PC : SRC_STACK;
                stk = pass ? STK_POP : STK_HOLD;
            end
            CONTINUE_OP: begin
                src = SRC_PC;
            end
            THREE_WAY_BRANCH_OP: begin
                if (pass) begin
                    // the external test overrides the counter
                    src = SRC_PC;
                    stk = STK_POP;
                    cnt = cntZero ? CNT_HOLD : CNT_DEC;
                end else if (!cntZero) begin
                    src = SRC_STACK;
                    cnt = CNT_DEC;
                end else begin
                    src = SRC_DATA;
                    stk = STK_POP;
                end
            end
            default: begin
                // codes outside this block fall back to sequential flow
                src = SRC_PC;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic [ADDR_WIDTH-1:0] selAddr;

    always_comb begin
        state_d = state_q;
        unique case (src)
            SRC_DATA:  selAddr = dataIn;
            SRC_STACK: selAddr = topWord;
            SRC_PC:    selAddr = state_q.pc;
            default:   selAddr = state_q.pc;
        endcase
        state_d.yAddr  = selAddr;
        state_d.pc     = selAddr + ADDR_ONE;
        state_d.plEn_n = 1'b0;

        unique case (cnt)
            CNT_LOAD: state_d.counter = dataIn;
            CNT_DEC:  state_d.counter = state_q.counter - ADDR_ONE;
            CNT_HOLD: state_d.counter = state_q.counter;
            default:  state_d.counter = state_q.counter;
        endcase
        state_d.zero = state_d.counter == '0;

        // push writes one past the top and the pointer follows it, so the
        // pointer keeps naming the slot after the newest entry; a push on a full stack is
        // dropped rather than overwriting the oldest return address
        unique case (stk)
            STK_PUSH: begin
                if (state_q.level != PTR_FULL) begin
                    state_d.stack[state_q.level] = state_q.pc;
                    state_d.level = state_q.level + PTR_ONE;
                end
            end
            STK_POP: begin
                // popping an empty stack leaves it empty
                if (state_q.level != PTR_EMPTY) begin
                    state_d.level = state_q.level - PTR_ONE;
                end
            end
            STK_HOLD: begin
                state_d.level = state_q.level;
            end
            default: begin
                state_d.level = state_q.level;
            end
        endcase
        state_d.full_n = state_d.level != PTR_FULL;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q.yAddr   <= ADDR_RESET;
            state_q.pc      <= PC_RESET;
            state_q.counter <= COUNTER_RESET;
            state_q.zero    <= 1'b1;
            state_q.level   <= PTR_EMPTY;
            state_q.full_n  <= 1'b1;
            state_q.plEn_n  <= 1'b1;
            state_q.stack   <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign nextAddr         = state_q.yAddr;
    assign counterValue     = state_q.counter;
    assign counterZero      = state_q.zero;
    assign stackLevel       = state_q.level;
    assign stackFull_n      = state_q.full_n;
    assign pipelineEnable_n = state_q.plEn_n;

endmodule

`default_nettype wire

// file: tb/msna_next_address_chk.sv
// port assertions for the next-address block
`default_nettype none
module msna_next_address_chk
    import msna_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input wire logic                       sys_clk,
    input wire logic                       rst_n,
    input wire logic [OPCODE_W-1:0]        opcode,
    input wire logic [ADDR_W-1:0]          dataIn,
    input wire logic                       cond_test_enable_n,
    input wire logic                       cond_input_n,
    input wire logic [ADDR_W-1:0]          nextAddr,
    input wire logic [ADDR_W-1:0]          counterValue,
    input wire logic                       counterZero,
    input wire logic [$clog2(DEPTH+1)-1:0] stackLevel
);
    wire logic fail = !cond_test_enable_n && cond_input_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_CONT: assert property (opcode == CONTINUE_OP |=> nextAddr == $past(nextAddr) + 12'h001)
        else $error("continue did not step");
    AST_REPEAT_DATA: assert property (opcode == REPEAT_FROM_PIPELINE_OP && !counterZero |=>
        nextAddr == $past(dataIn) && counterValue == $past(counterValue) - 12'h001)
        else $error("repeat did not branch and count");
    AST_REPEAT_STACK: assert property (opcode == REPEAT_FROM_PIPELINE_OP |=> $stable(stackLevel))
        else $error("repeat moved the stack");
    AST_RETURN_FAIL: assert property (opcode == COND_RETURN_OP && fail |=>
        nextAddr == $past(nextAddr) + 12'h001 && $stable(stackLevel))
        else $error("failed return left sequence");
    AST_JUMP_POP: assert property (opcode == COND_JUMP_POP_OP && !fail && stackLevel != 0 |=>
        nextAddr == $past(dataIn) && stackLevel == $past(stackLevel) - 1'b1)
        else $error("jump and pop wrong");
    AST_JUMP_KEEP: assert property (opcode == COND_JUMP_POP_OP && fail |=> $stable(stackLevel))
        else $error("failed jump touched stack");
    AST_LOAD: assert property (opcode == LOAD_COUNTER_CONTINUE_OP |=>
        counterValue == $past(dataIn) && nextAddr == $past(nextAddr) + 12'h001)
        else $error("counter load wrong");
    AST_LOOP_HOLD: assert property (opcode == END_OF_LOOP_OP && fail |=> $stable(stackLevel))
        else $error("loop popped on fail");
    AST_TWB_PASS: assert property (opcode == THREE_WAY_BRANCH_OP && !fail && stackLevel != 0 |=>
        nextAddr == $past(nextAddr) + 12'h001 && stackLevel == $past(stackLevel) - 1'b1)
        else $error("three-way pass wrong");
    AST_TWB_TIMEOUT: assert property (opcode == THREE_WAY_BRANCH_OP && fail && counterZero
        && stackLevel != 4'h0 |=> nextAddr == $past(dataIn)
        && stackLevel == $past(stackLevel) - 1'b1)
        else $error("three-way timeout wrong");
endmodule
bind msna_next_address msna_next_address_chk #(.DEPTH(DEPTH)) i_chk (.sys_clk(sys_clk),
    .rst_n(rst_n), .opcode(opcode), .dataIn(dataIn), .cond_test_enable_n(cond_test_enable_n),
    .cond_input_n(cond_input_n), .nextAddr(nextAddr), .counterValue(counterValue),
    .counterZero(counterZero), .stackLevel(stackLevel));
`default_nettype wire

// file: tb/msna_ucode_mem.sv
// microcode memory stand-in answering the sequencer address
`default_nettype none
module msna_ucode_mem
    import msna_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr,
    output var  logic [ADDR_W-1:0] word
);
    // contents follow the address so every word differs from its neighbours
    assign word = addr * 12'h025 + 12'h005;
endmodule
`default_nettype wire

// file: tb/msna_next_address_bench.sv
// self-checking bench for the next-address block
`default_nettype none
module msna_next_address_bench
    import msna_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                sys_clk, rst_n, cond_test_enable_n, cond_input_n;
    logic [OPCODE_W-1:0] opcode;
    logic [ADDR_W-1:0]   dataIn, nextAddr, counterValue, memWord, mAddr, mCnt;
    logic [3:0]          stackLevel;
    logic                counterZero, stackFull_n, pipelineEnable_n;
    logic [ADDR_W-1:0]   mStk [STACK_DEPTH];
    int                  mLvl, miscompares, total_checks;
    logic [OPCODE_W-1:0] rop;

    msna_next_address i_msna_next_address (.sys_clk(sys_clk), .rst_n(rst_n), .opcode(opcode),
        .dataIn(dataIn), .cond_test_enable_n(cond_test_enable_n), .cond_input_n(cond_input_n),
        .nextAddr(nextAddr), .counterValue(counterValue), .counterZero(counterZero),
        .stackLevel(stackLevel), .stackFull_n(stackFull_n), .pipelineEnable_n(pipelineEnable_n));
    msna_ucode_mem i_msna_ucode_mem (.addr(nextAddr), .word(memWord));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [ADDR_W-1:0] seen, input logic [ADDR_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic compare_all();
        check(nextAddr, mAddr);
        check(counterValue, mCnt);
        check(12'(counterZero), 12'(mCnt == 0));
        check(12'(stackLevel), 12'(mLvl));
        check(12'(stackFull_n), 12'(mLvl != STACK_DEPTH));
    endtask

    // drive one instruction, advance the reference, compare a cycle later
    task automatic step(input logic [3:0] op, input logic [ADDR_W-1:0] d, input logic en_n, c_n);
        logic pass, pop;
        logic [ADDR_W-1:0] pc, top;
        pass = en_n || !c_n;
        pop = 1'b0;
        pc = mAddr + 12'h001;
        top = mStk[mLvl == 0 ? 0 : mLvl - 1];
        opcode = op;
        dataIn = d;
        cond_test_enable_n = en_n;
        cond_input_n = c_n;
        mAddr = pc;
        case (op)
            PUSH_LOAD_OP: begin
                if (mLvl < STACK_DEPTH) mStk[mLvl++] = pc;
                if (pass) mCnt = d;
            end
            REPEAT_FROM_PIPELINE_OP: if (mCnt != 0) begin
                mAddr = d;
                mCnt--;
            end
            COND_RETURN_OP: if (pass) {mAddr, pop} = {top, 1'b1};
            COND_JUMP_POP_OP: if (pass) {mAddr, pop} = {d, 1'b1};
            LOAD_COUNTER_CONTINUE_OP: mCnt = d;
            END_OF_LOOP_OP: if (pass) pop = 1'b1; else mAddr = top;
            THREE_WAY_BRANCH_OP: begin
                if (pass) pop = 1'b1;
                else if (mCnt != 0) mAddr = top;
                else {mAddr, pop} = {d, 1'b1};
                if (mCnt != 0) mCnt--;
            end
            default: ;
        endcase
        if (pop && mLvl > 0) mLvl--;
        @(negedge sys_clk);
        compare_all();
        check(12'(pipelineEnable_n), 12'h000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h6e5dbc1d));
        {rst_n, opcode, dataIn, cond_test_enable_n, cond_input_n} = {1'b0, CONTINUE_OP, 14'h0002};
        {mAddr, mCnt, mLvl, miscompares, total_checks} = {ADDR_RESET, COUNTER_RESET, 96'h0};
        // design clears its stack in reset, so an empty-stack read before the first push sees zero
        foreach (mStk[i]) mStk[i] = '0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        compare_all();
        step(LOAD_COUNTER_CONTINUE_OP, 12'h003, 1'b1, 1'b0);
        step(PUSH_LOAD_OP, 12'h000, 1'b0, 1'b1);
        repeat (4) step(THREE_WAY_BRANCH_OP, 12'h5A0, 1'b0, 1'b1);
        step(PUSH_LOAD_OP, 12'h002, 1'b1, 1'b1);
        repeat (2) step(END_OF_LOOP_OP, 12'h000, 1'b0, 1'b1);
        step(END_OF_LOOP_OP, 12'h000, 1'b0, 1'b0);
        repeat (3) step(REPEAT_FROM_PIPELINE_OP, 12'h0C3, 1'b0, 1'b1);
        // one push beyond capacity must be dropped
        repeat (STACK_DEPTH + 1) step(PUSH_LOAD_OP, 12'h001, 1'b0, 1'b1);
        for (int k = 0; k < 64; k++) step(4'(k >> 2), memWord, k[1], k[0]);
        repeat (2000) begin
            rop = 4'($urandom_range(15, 0));
            // keep the empty stack from being read in random traffic
            if (mLvl == 0 && rop inside {COND_RETURN_OP, END_OF_LOOP_OP, THREE_WAY_BRANCH_OP})
                rop = PUSH_LOAD_OP;
            step(rop, memWord, 1'($urandom), 1'($urandom));
        end
        complete_run();
    end

    initial begin
        #(25 * 4000);
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire
